// File: stt_chk.sv
// Port assertions for the trigger block.
// Assumes it is bound into stt_trigger and sees only its ports.
module stt_chk
    import stt_pkg::*;
(
    // Watched ports.
    input wire logic       clk_i,
    input wire logic       reset_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_write_i,
    input wire logic       reg_read_i,
    input wire logic       reg_hit_o,
    input wire logic [1:0] trigger_irq_o,
    input wire logic       soft_reset_o,
    input wire logic [2:0] gpio_sel_i,
    input wire logic       mic_converter_clock_i,
    input wire logic       gpio_test_active_o,
    input wire logic       mic_converter_clock_out_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    wire clr1 = reg_write_i && reg_addr_i == TRIG_ONE_CONFIG_ADDR && !reg_wdata_i[ENABLE_BIT];
    wire clr2 = reg_write_i && reg_addr_i == TRIG_TWO_CONFIG_ADDR && !reg_wdata_i[ENABLE_BIT];
    a_clear_one: assert property (clr1 |=> !trigger_irq_o[0])
        else $error("irq one not cleared");
    a_clear_two: assert property (clr2 |=> !trigger_irq_o[1])
        else $error("irq two not cleared");
    a_irq_hold: assert property (trigger_irq_o[0] && !clr1 && !soft_reset_o |=> trigger_irq_o[0])
        else $error("irq one dropped");
    a_soft_cause: assert property (reg_write_i && reg_addr_i == TEST_RESET_ADDR
        && reg_wdata_i[SOFT_RESET_BIT] && !soft_reset_o |=> soft_reset_o)
        else $error("no soft reset");
    a_soft_pulse: assert property (soft_reset_o |=> !soft_reset_o && trigger_irq_o == 2'h0)
        else $error("soft reset pulse wrong");
    a_read_hit: assert property (reg_read_i && reg_addr_i >= TRIG_ONE_CONFIG_ADDR
        && reg_addr_i <= TEST_RESET_ADDR && !soft_reset_o |=> reg_hit_o)
        else $error("mapped read missed");
    a_gpio_sel: assert property (gpio_test_active_o |-> $past(gpio_sel_i) == GPIO_SEL_MIC)
        else $error("test routing on wrong code");
    a_mic_clock: assert property (gpio_test_active_o
        |-> mic_converter_clock_out_o == $past(mic_converter_clock_i))
        else $error("clock not routed");
endmodule
bind stt_trigger stt_chk chk_i (
    .clk_i                     (clk_i),
    .reset_n_i                 (reset_n_i),
    .reg_addr_i                (reg_addr_i),
    .reg_wdata_i               (reg_wdata_i),
    .reg_write_i               (reg_write_i),
    .reg_read_i                (reg_read_i),
    .reg_hit_o                 (reg_hit_o),
    .trigger_irq_o             (trigger_irq_o),
    .soft_reset_o              (soft_reset_o),
    .gpio_sel_i                (gpio_sel_i),
    .mic_converter_clock_i     (mic_converter_clock_i),
    .gpio_test_active_o        (gpio_test_active_o),
    .mic_converter_clock_out_o (mic_converter_clock_out_o)
);

// File: stt_mic.sv
// Digital microphone and converter clock model.
// Assumes clk_i is the block clock; both lines change on its rising edge.
module stt_mic
(
    input  wire logic clk_i,
    output logic      mic_clock_o,
    output logic      mic_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] count = 3'h0;
    always @(posedge clk_i)
    begin
        count <= count + 3'h1;
    end
    // The data never rests, so a stale routing path shows.
    assign mic_clock_o = count[0];
    assign mic_data_o  = count[1] ^ count[2];
endmodule

// File: stt_pkg.sv
// Constants for the SAR threshold trigger and test register block.
// Assumes an 8-bit register file reached through the control port front end.
package stt_pkg;
    localparam logic [7:0] TRIG_ONE_CONFIG_ADDR  = 8'h22;
    localparam logic [7:0] TRIG_ONE_THRESH_ADDR  = 8'h23;
    localparam logic [7:0] TRIG_TWO_CONFIG_ADDR  = 8'h24;
    localparam logic [7:0] TRIG_TWO_THRESH_ADDR  = 8'h25;
    localparam logic [7:0] TEST_RESET_ADDR       = 8'h26;

    localparam int ENABLE_BIT      = 0;
    localparam int DIRECTION_BIT   = 1;
    localparam int CHANNEL_LSB     = 2;
    localparam int CHANNEL_MSB     = 3;
    localparam int LOW_NIBBLE_LSB  = 4;
    localparam int LOW_NIBBLE_MSB  = 7;
    localparam int SOFT_RESET_BIT  = 3;
    localparam int GPIO_TEST_BIT   = 7;

    localparam logic [7:0] CONFIG_RESET    = 8'h00;
    localparam logic [7:0] THRESH_RESET    = 8'h00;
    localparam logic       GPIO_TEST_RESET = 1'b0;

    localparam logic [2:0] GPIO_SEL_MIC       = 3'h2;
    localparam logic [1:0] AUDIO_IF_EXCLUDED  = 2'h3;
    localparam logic       DIR_ABOVE          = 1'b0;
endpackage

// File: stt_trigger.sv
// Two SAR threshold triggers, the debug register with soft reset and the GPIO microphone test mode.
// Assumes register accesses and SAR samples arrive as single-cycle strobes synchronous to clk_i.
//
// Summary of operation
// - Trigger two enable bit 0; clearing clears pending
// - Trigger two bit 1: 0 above, 1 below
// - Trigger two bits 3:2 pick watched channel
// - Config bits 7:4 give threshold bits 3:0
// - High registers 0x23/0x25 give bits 11:4
// - Debug bit 3 resets the whole chip
// - Test mode 010 routes microphone clock and data, except in audio interface mode 3
// - Trigger one enable bit 0; clearing clears pending
// - Trigger one bit 1: 0 above, 1 below
// - Trigger one bits 3:2 same channel encoding
module stt_trigger
    import stt_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Register access from the control port.
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             reg_hit_o,
    // SAR results.
    input  wire logic        sample_valid_i,
    input  wire logic [1:0]  sample_slot_i,
    input  wire logic [11:0] sample_data_i,
    // Interrupts and chip reset.
    output logic      [1:0]  trigger_irq_o,
    output logic             irq_o,
    output logic             soft_reset_o,
    // GPIO test mode.
    input  wire logic [2:0]  gpio_sel_i,
    input  wire logic [1:0]  audio_if_mode_i,
    input  wire logic        mic_converter_clock_i,
    input  wire logic        gpio2_pin_i,
    output logic             gpio_test_active_o,
    output logic             mic_converter_clock_out_o,
    output logic             gpio1_oe_o,
    output logic             microphone_bitstream_in_o
);
    logic [7:0]  trig_config [2];
    logic [7:0]  trig_thresh [2];
    logic        gpio_test;
    logic [1:0]  pending;
    logic [11:0] last_sample [4];
    logic [3:0]  last_valid;
    logic [7:0]  next_trig_config [2];
    logic [7:0]  next_trig_thresh [2];
    logic        next_gpio_test;
    logic [1:0]  next_pending;
    logic [11:0] next_last_sample [4];
    logic [3:0]  next_last_valid;
    logic [7:0]  next_rdata;
    logic        next_hit;
    logic        next_soft_reset;
    logic        next_test_active;
    logic        clear_all;
    logic [1:0]  crossed;
    logic [1:0]  enabled;
    logic        next_irq;
    logic        next_mic_clock;
    logic        next_mic_data;

    // A soft reset returns this block's own registers to their reset values one cycle later as well.
    assign clear_all = !reset_n_i || soft_reset_o;

    always_comb
    begin
        next_trig_config = trig_config;
        next_trig_thresh = trig_thresh;
        next_gpio_test   = gpio_test;
        next_soft_reset  = 1'b0;
        next_rdata       = 8'h00;
        next_hit         = 1'b0;
        if (reg_write_i)
        begin
            unique case (reg_addr_i)
                TRIG_ONE_CONFIG_ADDR: next_trig_config[0] = reg_wdata_i;
                TRIG_ONE_THRESH_ADDR: next_trig_thresh[0] = reg_wdata_i;
                TRIG_TWO_CONFIG_ADDR: next_trig_config[1] = reg_wdata_i;
                TRIG_TWO_THRESH_ADDR: next_trig_thresh[1] = reg_wdata_i;
                TEST_RESET_ADDR:
                begin
                    next_gpio_test  = reg_wdata_i[GPIO_TEST_BIT];
                    next_soft_reset = reg_wdata_i[SOFT_RESET_BIT];
                end
                default: next_gpio_test = gpio_test;
            endcase
        end
        if (reg_read_i)
        begin
            next_hit = 1'b1;
            unique case (reg_addr_i)
                TRIG_ONE_CONFIG_ADDR: next_rdata = trig_config[0];
                TRIG_ONE_THRESH_ADDR: next_rdata = trig_thresh[0];
                TRIG_TWO_CONFIG_ADDR: next_rdata = trig_config[1];
                TRIG_TWO_THRESH_ADDR: next_rdata = trig_thresh[1];
                // The soft reset bit is an action and reads back as zero.
                TEST_RESET_ADDR:      next_rdata = {gpio_test, 7'h00};
                default:              next_hit   = 1'b0;
            endcase
        end
    end

    // Every slot remembers its previous result so a crossing needs one sample on each side.
    always_comb
    begin
        next_last_sample = last_sample;
        next_last_valid  = last_valid;
        if (sample_valid_i)
        begin
            next_last_sample[sample_slot_i] = sample_data_i;
            next_last_valid[sample_slot_i]  = 1'b1;
        end
    end

    // Each trigger looks only at samples of its own channel and yields one crossing strobe.
    genvar t;
    generate
        for (t = 0; t < 2; t++)
        begin : g_trig
            logic [11:0] threshold;
            logic [1:0]  channel;
            logic [11:0] previous;
            logic        fresh;
            logic        rising;
            logic        falling;

            assign threshold  = {trig_thresh[t], trig_config[t][LOW_NIBBLE_MSB:LOW_NIBBLE_LSB]};
            assign channel    = trig_config[t][CHANNEL_MSB:CHANNEL_LSB];
            assign previous   = last_sample[channel];
            // The first sample of a slot after reset has nothing to compare against and only primes it.
            assign fresh      = sample_valid_i && sample_slot_i == channel && last_valid[channel];
            // Equality on the old side counts, so a signal resting on the threshold fires once it leaves.
            assign rising     = previous <= threshold && sample_data_i > threshold;
            assign falling    = previous >= threshold && sample_data_i < threshold;
            assign crossed[t] = fresh && (trig_config[t][DIRECTION_BIT] == DIR_ABOVE ? rising : falling);
            assign enabled[t] = next_trig_config[t][ENABLE_BIT];
        end
    endgenerate

    // A write that clears the enable wins over a crossing in the same cycle.
    // Otherwise a late crossing could survive the clear the host has just made.
    always_comb
    begin
        next_pending = enabled & (pending | crossed);
        next_irq     = |next_pending;
    end

    // Mode 010 is the only defined test routing; other codes leave the GPIOs alone.
    always_comb
    begin
        next_test_active = gpio_test && gpio_sel_i == GPIO_SEL_MIC && audio_if_mode_i != AUDIO_IF_EXCLUDED;
        next_mic_clock   = next_test_active && mic_converter_clock_i;
        next_mic_data    = next_test_active && gpio2_pin_i;
    end

    // Register file and soft reset strobe; a soft reset clears this block like the pin reset.
    always_ff @(posedge clk_i)
    begin
        if (clear_all)
        begin
            trig_config  <= '{CONFIG_RESET, CONFIG_RESET};
            trig_thresh  <= '{THRESH_RESET, THRESH_RESET};
            gpio_test    <= GPIO_TEST_RESET;
            reg_rdata_o  <= 8'h00;
            reg_hit_o    <= 1'b0;
            soft_reset_o <= 1'b0;
        end
        else
        begin
            trig_config  <= next_trig_config;
            trig_thresh  <= next_trig_thresh;
            gpio_test    <= next_gpio_test;
            reg_rdata_o  <= next_rdata;
            reg_hit_o    <= next_hit;
            soft_reset_o <= next_soft_reset;
        end
    end

    // Last result of every slot.
    always_ff @(posedge clk_i)
    begin
        if (clear_all)
        begin
            last_sample <= '{12'h000, 12'h000, 12'h000, 12'h000};
            last_valid  <= 4'h0;
        end
        else
        begin
            last_sample <= next_last_sample;
            last_valid  <= next_last_valid;
        end
    end

    // Pending interrupts and their registered copies on the pins.
    always_ff @(posedge clk_i)
    begin
        if (clear_all)
        begin
            pending       <= 2'h0;
            trigger_irq_o <= 2'h0;
            irq_o         <= 1'b0;
        end
        else
        begin
            pending       <= next_pending;
            trigger_irq_o <= next_pending;
            irq_o         <= next_irq;
        end
    end

    // Test routing outputs; the routed clock and data lag their inputs by one cycle.
    always_ff @(posedge clk_i)
    begin
        if (clear_all)
        begin
            gpio_test_active_o        <= 1'b0;
            mic_converter_clock_out_o <= 1'b0;
            gpio1_oe_o                <= 1'b0;
            microphone_bitstream_in_o <= 1'b0;
        end
        else
        begin
            gpio_test_active_o        <= next_test_active;
            mic_converter_clock_out_o <= next_mic_clock;
            gpio1_oe_o                <= next_test_active;
            microphone_bitstream_in_o <= next_mic_data;
        end
    end
endmodule

// File: testbench.sv
// Self-checking bench for the trigger block.
// Assumes inputs are sampled on the rising edge of clk_i.
module testbench
    import stt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        valid = 1'b0;
    logic [1:0]  slot = 2'h0;
    logic [11:0] sdata = 12'h000;
    logic [2:0]  sel = 3'h0;
    logic [1:0]  mode = 2'h0;
    logic [1:0]  tirq;
    logic        hit, sr, act, oe, mdata, mclk, mdat, irq, e, p, mco, c;
    int          n_fail = 0;
    int          comparisons = 0;
    stt_trigger dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(wr_en), .reg_read_i(rd_en), .reg_rdata_o(rdata), .reg_hit_o(hit),
        .sample_valid_i(valid), .sample_slot_i(slot), .sample_data_i(sdata), .trigger_irq_o(tirq),
        .irq_o(irq), .soft_reset_o(sr), .gpio_sel_i(sel), .audio_if_mode_i(mode),
        .mic_converter_clock_i(mclk), .gpio2_pin_i(mdat), .gpio_test_active_o(act),
        .mic_converter_clock_out_o(mco), .gpio1_oe_o(oe), .microphone_bitstream_in_o(mdata));
    stt_mic mic (.clk_i(clk_i), .mic_clock_o(mclk), .mic_data_o(mdat));
    initial forever #25 clk_i = ~clk_i;
    task automatic chk(input logic [11:0] s, input logic [11:0] x);
        comparisons++;
        if (s !== x)
        begin
            n_fail++;
            $display("mismatch %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) #1 {addr, wdata, wr_en} = {a, d, 1'b1};
        @(posedge clk_i) #1 wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [8:0] x);
        @(posedge clk_i) #1 {addr, rd_en} = {a, 1'b1};
        @(posedge clk_i) #1 rd_en = 1'b0;
        chk({3'h0, hit, rdata}, {3'h0, x});
    endtask
    task automatic smp(input logic [1:0] s, input logic [11:0] d);
        @(posedge clk_i) #1 {valid, slot, sdata} = {1'b1, s, d};
        @(posedge clk_i) #1 valid = 1'b0;
    endtask
    task automatic finish_test();
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        for (int a = 8'h22; a < 8'h28; a++)
            rd(8'(a), {a != 8'h27, 8'h00});
        wr(TRIG_ONE_THRESH_ADDR, 8'h80);
        wr(TRIG_ONE_CONFIG_ADDR, 8'h01);
        rd(TRIG_ONE_CONFIG_ADDR, 9'h101);
        smp(2'h0, 12'h700);
        smp(2'h0, 12'h900);
        chk({9'h0, irq, tirq}, 12'h5);
        smp(2'h0, 12'h700);
        chk({9'h0, irq, tirq}, 12'h5);
        wr(TRIG_ONE_CONFIG_ADDR, 8'h03);
        chk({9'h0, irq, tirq}, 12'h5);
        wr(TRIG_ONE_CONFIG_ADDR, 8'h02);
        chk({9'h0, irq, tirq}, 12'h0);
        wr(TRIG_ONE_CONFIG_ADDR, 8'h03);
        smp(2'h0, 12'h900);
        smp(2'h0, 12'h800);
        chk({9'h0, irq, tirq}, 12'h0);
        smp(2'h0, 12'h7FF);
        chk({9'h0, irq, tirq}, 12'h5);
        wr(TRIG_ONE_CONFIG_ADDR, 8'h00);
        // Threshold 0x10A sits on the boundary, so a lost low nibble shows.
        wr(TRIG_TWO_THRESH_ADDR, 8'h10);
        for (int i = 0; i < 8; i++)
        begin
            wr(TRIG_TWO_CONFIG_ADDR, {4'hA, 2'(i), i[2], 1'b1});
            smp(2'(i + 1), 12'h10A);
            smp(2'(i + 1), i[2] ? 12'h109 : 12'h10B);
            chk({10'h0, tirq}, 12'h0);
            smp(2'(i), 12'h10A);
            smp(2'(i), i[2] ? 12'h109 : 12'h10B);
            chk({9'h0, irq, tirq}, 12'h6);
            wr(TRIG_TWO_CONFIG_ADDR, 8'hA0);
            chk({10'h0, tirq}, 12'h0);
        end
        rd(TRIG_TWO_CONFIG_ADDR, 9'h1A0);
        wr(TEST_RESET_ADDR, 8'h80);
        rd(TEST_RESET_ADDR, 9'h180);
        for (int i = 0; i < 12; i++)
        begin
            {sel, mode} = i < 8 ? {3'(i), 2'h0} : {3'h2, 2'(i)};
            e = i == 2 || (i > 7 && i != 11);
            repeat (2) @(posedge clk_i);
            #1 {p, c} = {mdat, mclk};
            chk({10'h0, act, oe}, e ? 12'h3 : 12'h0);
            @(posedge clk_i) #1 chk({11'h0, mdata}, {11'h0, e & p});
            chk({11'h0, mco}, {11'h0, e & c});
        end
        wr(TEST_RESET_ADDR, 8'h88);
        chk({11'h0, sr}, 12'h1);
        rd(TRIG_ONE_THRESH_ADDR, 9'h100);
        rd(TEST_RESET_ADDR, 9'h100);
        finish_test();
    end
endmodule
